// ---- exec_pkg.sv ----
package exec_pkg;
  localparam int DATA_W       = 8;
  localparam int REG_IDX_W    = 7;
  localparam int SFR_IDX_W    = 5;
  localparam int SFR_COUNT    = 22;
  localparam int NIBBLE_W     = 4;
  localparam int WATCHDOG_W   = 8;
  localparam int DIV_W        = 8;
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [WATCHDOG_W-1:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [DIV_W-1:0]  DIV_CLEAR = 8'h00;
  localparam logic [DATA_W-1:0] SFR_RST  = 8'h00;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_REG  = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_CARRY,
    OP_REG_SUB_BORROW,
    OP_IMM_SUB_BORROW,
    OP_SPECIAL_REG_WRITE,
    OP_SPECIAL_REG_READ,
    OP_HALT
  } op_t;
endpackage

// ---- sub_borrow_unit.sv ----
`timescale 1ns/1ps
module sub_borrow_unit
  import exec_pkg::*;
(
  input  wire logic [exec_pkg::DATA_W-1:0] minuend,
  input  wire logic [exec_pkg::DATA_W-1:0] subtrahend,
  input  wire logic                        carry_in,
  output logic      [exec_pkg::DATA_W-1:0] result,
  output logic                             carry_out,
  output logic                             half_carry_out,
  output logic                             zero_out
);
  logic [DATA_W:0]   full_sum;
  logic [NIBBLE_W:0] low_sum;

  // Minuend plus inverted subtrahend plus carry
  always_comb begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, carry_in};
    low_sum  = {1'b0, minuend[NIBBLE_W-1:0]} + {1'b0, ~subtrahend[NIBBLE_W-1:0]}
             + {{NIBBLE_W{1'b0}}, carry_in};
    result         = full_sum[DATA_W-1:0];
    carry_out      = full_sum[DATA_W];
    half_carry_out = low_sum[NIBBLE_W];
    zero_out       = (full_sum[DATA_W-1:0] == ZERO_BYTE);
  end
endmodule // sub_borrow_unit

// ---- exec_unit.sv ----
// Operation
// - Rotate right through carry: carry into bit 7, bit 0 into carry.
// - Rotate and register subtract: destination bit zero writes work register, one writes back to register.
// - Register subtract with borrow: reg plus inverted work plus carry, flags.
// - Immediate subtract with borrow: imm plus inverted work plus carry into work.
// - Special write copies work register into S-page register 0..21, no flags.
// - Special read copies S-page register 0..21 into work register, no flags.
// - Halt clears watchdog counter and divider, then enters halt mode.
// - Subtract carry is inverted borrow; zero flag marks zero result.
`timescale 1ns/1ps
module exec_unit
  import exec_pkg::*;
#(
  parameter int SFR_N = exec_pkg::SFR_COUNT
) (
  input  wire logic                           core_clk,
  input  wire logic                           resetn,
  input  wire logic                           clk_en,
  input  wire exec_pkg::op_t                  op,
  input  wire logic                           dest_sel,
  input  wire logic [exec_pkg::REG_IDX_W-1:0] reg_idx,
  input  wire logic [exec_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [exec_pkg::DATA_W-1:0]    imm_data,
  input  wire logic [exec_pkg::SFR_IDX_W-1:0] sfr_idx,
  input  wire logic                           wake,
  output logic      [exec_pkg::DATA_W-1:0]    work_register,
  output logic                                carry_flag,
  output logic                                half_carry_flag,
  output logic                                zero_flag,
  output logic                                timeout_flag,
  output logic                                power_down_flag,
  output logic      [exec_pkg::WATCHDOG_W-1:0] watchdog_counter,
  output logic      [exec_pkg::DIV_W-1:0]     watchdog_divider,
  output logic                                halted,
  output logic                                reg_we,
  output logic      [exec_pkg::REG_IDX_W-1:0] reg_waddr,
  output logic      [exec_pkg::DATA_W-1:0]    reg_wdata
);
  import exec_pkg::*;

  logic                rst_sync1_ff;
  logic                rst_sync2_ff;
  logic                rst_n;
  logic [DATA_W-1:0]   sfr_ff [SFR_N];
  logic [DATA_W-1:0]   sub_a;
  logic [DATA_W-1:0]   sub_res;
  logic                sub_c;
  logic                sub_hc;
  logic                sub_z;
  logic [DATA_W-1:0]   nxt_result;
  logic                nxt_carry;
  logic                is_sub;

  function automatic logic sfr_hit(input logic [SFR_IDX_W-1:0] idx, input int k);
    return (int'(idx) == k);
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n = rst_sync2_ff;

  assign is_sub = (op == OP_REG_SUB_BORROW) || (op == OP_IMM_SUB_BORROW);
  assign sub_a  = (op == OP_IMM_SUB_BORROW) ? imm_data : reg_rdata;

  sub_borrow_unit u_sub (
    .minuend        (sub_a),
    .subtrahend     (work_register),
    .carry_in       (carry_flag),
    .result         (sub_res),
    .carry_out      (sub_c),
    .half_carry_out (sub_hc),
    .zero_out       (sub_z)
  );

  always_comb begin
    nxt_result = work_register;
    nxt_carry  = carry_flag;
    case (op)
      OP_ROTATE_RIGHT_CARRY: begin
        nxt_result = {carry_flag, reg_rdata[DATA_W-1:1]};
        nxt_carry  = reg_rdata[0];
      end
      OP_REG_SUB_BORROW, OP_IMM_SUB_BORROW: begin
        nxt_result = sub_res;
        nxt_carry  = sub_c;
      end
      default: begin
        nxt_result = work_register;
        nxt_carry  = carry_flag;
      end
    endcase
  end

  // Work register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_register <= WORK_RST;
    end else if (clk_en && !halted) begin
      case (op)
        OP_ROTATE_RIGHT_CARRY, OP_REG_SUB_BORROW: begin
          if (dest_sel == DEST_WORK) begin
            work_register <= nxt_result;
          end
        end
        OP_IMM_SUB_BORROW: begin
          work_register <= nxt_result;
        end
        OP_SPECIAL_REG_READ: begin
          if (int'(sfr_idx) < SFR_N) begin
            work_register <= sfr_ff[sfr_idx];
          end
        end
        default: begin
          work_register <= work_register;
        end
      endcase
    end
  end

  // Write back to data register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_we    <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= ZERO_BYTE;
    end else if (clk_en) begin
      reg_we    <= !halted && (op == OP_ROTATE_RIGHT_CARRY || op == OP_REG_SUB_BORROW)
                   && dest_sel == DEST_REG;
      reg_waddr <= reg_idx;
      reg_wdata <= nxt_result;
    end
  end

  // Arithmetic flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag      <= 1'b0;
      half_carry_flag <= 1'b0;
      zero_flag       <= 1'b0;
    end else if (clk_en && !halted) begin
      if (op == OP_ROTATE_RIGHT_CARRY || is_sub) begin
        carry_flag <= nxt_carry;
      end
      if (is_sub) begin
        half_carry_flag <= sub_hc;
        zero_flag       <= sub_z;
      end
    end
  end

  // S-page special registers
  for (genvar k = 0; k < SFR_N; k++) begin : g_sfr
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        sfr_ff[k] <= SFR_RST;
      end else if (clk_en && !halted && op == OP_SPECIAL_REG_WRITE && sfr_hit(sfr_idx, k)) begin
        sfr_ff[k] <= work_register;
      end
    end
  end

  // Halt, watchdog clear and power flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      halted           <= 1'b0;
      watchdog_counter <= WATCHDOG_CLEAR;
      watchdog_divider <= DIV_CLEAR;
      timeout_flag     <= 1'b1;
      power_down_flag  <= 1'b1;
    end else if (clk_en) begin
      if (!halted && op == OP_HALT) begin
        watchdog_counter <= WATCHDOG_CLEAR;
        watchdog_divider <= DIV_CLEAR;
        halted           <= 1'b1;
        timeout_flag     <= 1'b1;
        power_down_flag  <= 1'b0;
      end else if (halted && wake) begin
        halted <= 1'b0;
      end
    end
  end

  property p_rotate;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_ROTATE_RIGHT_CARRY)
      |=> carry_flag == $past(reg_rdata[0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

  property p_dest;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_REG_SUB_BORROW && dest_sel == DEST_REG)
      |=> reg_we && $stable(work_register);
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong");

  property p_reg_sub;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_REG_SUB_BORROW && dest_sel == DEST_WORK)
      |=> work_register == $past(reg_rdata + ~work_register + {7'h00, carry_flag});
  endproperty
  a_reg_sub: assert property (p_reg_sub) else $error("register subtract wrong");

  property p_imm_sub;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_IMM_SUB_BORROW)
      |=> work_register == $past(imm_data + ~work_register + {7'h00, carry_flag}) && !reg_we;
  endproperty
  a_imm_sub: assert property (p_imm_sub) else $error("immediate subtract wrong");

  property p_sfr_rw;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_SPECIAL_REG_WRITE)
      |=> $stable(carry_flag) && $stable(zero_flag) && $stable(half_carry_flag);
  endproperty
  a_sfr_rw: assert property (p_sfr_rw) else $error("special write touched flags");

  property p_sfr_rd;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && op == OP_SPECIAL_REG_READ)
      |=> $stable(carry_flag) && $stable(zero_flag);
  endproperty
  a_sfr_rd: assert property (p_sfr_rd) else $error("special read touched flags");

  sequence s_halt_issue;
    clk_en && !halted && op == OP_HALT;
  endsequence
  sequence s_halt_done;
    halted && watchdog_counter == WATCHDOG_CLEAR && watchdog_divider == DIV_CLEAR;
  endsequence
  property p_halt;
    @(posedge core_clk) disable iff (!rst_n) s_halt_issue |=> s_halt_done;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not clear watchdog");

  property p_halt_flags;
    @(posedge core_clk) disable iff (!rst_n)
      s_halt_issue |=> timeout_flag && !power_down_flag && $stable(carry_flag);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt power flags wrong");

  property p_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && is_sub)
      |=> zero_flag == ($past(sub_a + ~work_register + {7'h00, carry_flag}) == ZERO_BYTE);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_half;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !halted && is_sub) |=> half_carry_flag ==
        $past(({1'b0, sub_a[NIBBLE_W-1:0]} + {1'b0, ~work_register[NIBBLE_W-1:0]}
               + {{NIBBLE_W{1'b0}}, carry_flag}) > {1'b0, {NIBBLE_W{1'b1}}});
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");
endmodule // exec_unit

// ---- rotate_subtract_sfr_halt_exec_test.sv ----
`timescale 1ns/1ps
module rotate_subtract_sfr_halt_exec_test;
  import exec_pkg::*;
  typedef struct {
    op_t        op;
    logic       d;
    logic [7:0] rd;
    logic [7:0] imm;
    logic [7:0] w0;
    logic       c0;
    logic [7:0] res;
    logic       c;
    logic       z;
    logic       hc;
  } row_t;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       clk_en = 1'b1;
  op_t        op = OP_NONE;
  logic       dest_sel = 1'b0;
  logic [6:0] reg_idx = 7'h00;
  logic [7:0] reg_rdata = 8'h00;
  logic [7:0] imm_data = 8'h00;
  logic [4:0] sfr_idx = 5'h00;
  logic       wake = 1'b0;
  logic [7:0] work_register;
  logic [7:0] watchdog_counter;
  logic [7:0] watchdog_divider;
  logic [7:0] reg_wdata;
  logic [6:0] reg_waddr;
  logic       carry_flag;
  logic       half_carry_flag;
  logic       zero_flag;
  logic       timeout_flag;
  logic       power_down_flag;
  logic       halted;
  logic       reg_we;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cycles = 0;
  logic       z_m = 1'b0;
  logic       hc_m = 1'b0;
  row_t       rows [10] = '{
    '{OP_ROTATE_RIGHT_CARRY, 1'b1, 8'ha5, 8'h00, 8'h00, 1'b0, 8'h52, 1'b1, 1'b0, 1'b0},
    '{OP_ROTATE_RIGHT_CARRY, 1'b0, 8'h81, 8'h00, 8'h00, 1'b1, 8'hc0, 1'b1, 1'b0, 1'b0},
    '{OP_REG_SUB_BORROW, 1'b1, 8'h05, 8'h00, 8'h06, 1'b0, 8'hfe, 1'b0, 1'b0, 1'b0},
    '{OP_REG_SUB_BORROW, 1'b1, 8'h05, 8'h00, 8'h06, 1'b1, 8'hff, 1'b0, 1'b0, 1'b0},
    '{OP_REG_SUB_BORROW, 1'b0, 8'h06, 8'h00, 8'h05, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
    '{OP_REG_SUB_BORROW, 1'b0, 8'h10, 8'h00, 8'h01, 1'b1, 8'h0f, 1'b1, 1'b0, 1'b0},
    '{OP_IMM_SUB_BORROW, 1'b1, 8'h00, 8'h05, 8'h06, 1'b0, 8'hfe, 1'b0, 1'b0, 1'b0},
    '{OP_IMM_SUB_BORROW, 1'b0, 8'h00, 8'h05, 8'h06, 1'b1, 8'hff, 1'b0, 1'b0, 1'b0},
    '{OP_IMM_SUB_BORROW, 1'b0, 8'h00, 8'h06, 8'h05, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1},
    '{OP_IMM_SUB_BORROW, 1'b1, 8'h00, 8'h06, 8'h05, 1'b1, 8'h01, 1'b1, 1'b0, 1'b1}};

  exec_unit u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .op(op), .dest_sel(dest_sel),
    .reg_idx(reg_idx), .reg_rdata(reg_rdata), .imm_data(imm_data), .sfr_idx(sfr_idx), .wake(wake),
    .work_register(work_register), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .zero_flag(zero_flag), .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
    .watchdog_counter(watchdog_counter), .watchdog_divider(watchdog_divider), .halted(halted),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata));

  always #2 core_clk = ~core_clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic issue(input op_t o, input logic d, input logic [7:0] rd, input logic [7:0] im,
                       input logic [4:0] si, input logic [6:0] ri);
    @(posedge core_clk);
    op <= o;
    dest_sel <= d;
    reg_rdata <= rd;
    imm_data <= im;
    sfr_idx <= si;
    reg_idx <= ri;
    @(posedge core_clk);
    op <= OP_NONE;
    #1;
  endtask

  // Two rotates into the work register leave it at w with carry c
  task automatic setup(input logic [7:0] w, input logic c);
    issue(OP_ROTATE_RIGHT_CARRY, DEST_WORK, {7'h00, w[7]}, 8'h00, 5'h00, 7'h00);
    issue(OP_ROTATE_RIGHT_CARRY, DEST_WORK, {w[6:0], c}, 8'h00, 5'h00, 7'h00);
  endtask

  task automatic summarize;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      $display("Error run_length expected %0d seen %0d", 3000, cycles);
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("timeout", 8'h01, timeout_flag);
    chk("power_down", 8'h01, power_down_flag);
    for (int i = 0; i < 10; i++) begin
      setup(rows[i].w0, rows[i].c0);
      issue(rows[i].op, rows[i].d, rows[i].rd, rows[i].imm, 5'h00, 7'(i + 3));
      if (rows[i].d && rows[i].op != OP_IMM_SUB_BORROW) begin
        chk("reg_we", 8'h01, reg_we);
        chk("reg_wdata", rows[i].res, reg_wdata);
        chk("reg_waddr", 8'(i + 3), {1'b0, reg_waddr});
        chk("work", rows[i].w0, work_register);
      end else begin
        chk("work", rows[i].res, work_register);
        chk("reg_we", 8'h00, reg_we);
      end
      chk("carry", rows[i].c, carry_flag);
      if (rows[i].op != OP_ROTATE_RIGHT_CARRY) begin
        z_m = rows[i].z;
        hc_m = rows[i].hc;
      end
      chk("zero", z_m, zero_flag);
      chk("half_carry", hc_m, half_carry_flag);
    end
    $display("Table test done");
    setup(8'h05, 1'b0);
    @(posedge core_clk);
    op <= OP_IMM_SUB_BORROW;
    imm_data <= 8'h06;
    repeat (2) @(posedge core_clk);
    op <= OP_NONE;
    #1;
    chk("work", 8'h06, work_register);
    chk("carry", 8'h01, carry_flag);
    chk("half_carry", 8'h01, half_carry_flag);
    chk("zero", 8'h00, zero_flag);
    $display("Back to back test done");
    setup(8'h3c, 1'b1);
    issue(OP_SPECIAL_REG_WRITE, DEST_WORK, 8'h00, 8'h00, 5'd21, 7'h00);
    chk("carry", 8'h01, carry_flag);
    setup(8'hc3, 1'b0);
    issue(OP_SPECIAL_REG_WRITE, DEST_WORK, 8'h00, 8'h00, 5'd0, 7'h00);
    issue(OP_SPECIAL_REG_WRITE, DEST_WORK, 8'h00, 8'h00, 5'd22, 7'h00);
    chk("work", 8'hc3, work_register);
    setup(8'h77, 1'b1);
    issue(OP_SPECIAL_REG_READ, DEST_WORK, 8'h00, 8'h00, 5'd21, 7'h00);
    chk("work", 8'h3c, work_register);
    chk("carry", 8'h01, carry_flag);
    chk("half_carry", 8'h01, half_carry_flag);
    issue(OP_SPECIAL_REG_READ, DEST_WORK, 8'h00, 8'h00, 5'd0, 7'h00);
    chk("work", 8'hc3, work_register);
    issue(OP_SPECIAL_REG_READ, DEST_WORK, 8'h00, 8'h00, 5'd22, 7'h00);
    chk("work", 8'hc3, work_register);
    $display("Special register test done");
    issue(OP_HALT, DEST_WORK, 8'h00, 8'h00, 5'h00, 7'h00);
    chk("halted", 8'h01, halted);
    chk("watchdog", 8'h00, watchdog_counter);
    chk("divider", 8'h00, watchdog_divider);
    chk("timeout", 8'h01, timeout_flag);
    chk("power_down", 8'h00, power_down_flag);
    chk("carry", 8'h01, carry_flag);
    chk("work", 8'hc3, work_register);
    issue(OP_IMM_SUB_BORROW, DEST_WORK, 8'h00, 8'h55, 5'h00, 7'h00);
    chk("work", 8'hc3, work_register);
    issue(OP_ROTATE_RIGHT_CARRY, DEST_REG, 8'hff, 8'h00, 5'h00, 7'h01);
    chk("reg_we", 8'h00, reg_we);
    @(posedge core_clk);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    #1;
    chk("halted", 8'h00, halted);
    @(posedge core_clk);
    clk_en <= 1'b0;
    issue(OP_IMM_SUB_BORROW, DEST_WORK, 8'h00, 8'h55, 5'h00, 7'h00);
    chk("work", 8'hc3, work_register);
    @(posedge core_clk);
    clk_en <= 1'b1;
    resetn <= 1'b0;
    #1;
    chk("work", 8'h00, work_register);
    chk("power_down", 8'h01, power_down_flag);
    chk("carry", 8'h00, carry_flag);
    chk("halted", 8'h00, halted);
    $display("Halt and reset test done");
    summarize();
  end
endmodule // rotate_subtract_sfr_halt_exec_test
